//--- core/veoc_map.vh
// register map, field positions and reset values of the encoder output configuration
// Behaviour
// (R1) reset low loads every default value
// (R2) sync-blanking bit only in three slave modes
// (R3) colour kill strips chroma from composite only
// (R4) pedestal off: blank equals black level
// (R5) pedestal on: black 7.5 IRE outside VBI
// (R6) chroma gain scaled per standard
// (R7) caption mode: none, field1, field2, both
// (R8) scan bit 0 gives interlaced 625/525
// (R9) second register resets to burst enable only
// (R10) scan bit 1 gives non-interlaced fields
// (R11) scan change applies at next frame start
// (R12) burst off suppresses composite burst only
// (R13) chroma filter bandwidth select, default 10
// (R14) blanking select wide or nominal VBI
`ifndef VEOC_MAP_VH
`define VEOC_MAP_VH
// ************
// register offsets (byte addresses, index times four)
// ************
`define VEOC_IDX_OPTIONS 8'h01
`define VEOC_IDX_SCANOSC 8'h02
`define VEOC_IDX_STATUS 8'h03
`define VEOC_IDX_MODE 8'h04
`define VEOC_ADDR_OPTIONS 8'h04
`define VEOC_ADDR_SCANOSC 8'h08
`define VEOC_ADDR_STATUS 8'h0c
`define VEOC_ADDR_MODE 8'h10
// ************
// field positions
// ************
`define VEOC_BIT_BLANK_SEL 7
`define VEOC_BIT_FLT_HI 6
`define VEOC_BIT_FLT_LO 5
`define VEOC_BIT_SYNC_BLANK 4
`define VEOC_BIT_COLOUR_KILL 3
`define VEOC_BIT_PEDESTAL 2
`define VEOC_BIT_CC_HI 1
`define VEOC_BIT_CC_LO 0
`define VEOC_BIT_NON_INTERLACED 7
`define VEOC_BIT_BURST_EN 5
// ************
// reset values
// ************
`define VEOC_RST_OPTIONS 8'h40
`define VEOC_RST_SCANOSC 8'h20
`define VEOC_RST_MODE 8'h00
// ************
// sync modes and levels
// ************
`define VEOC_SYNC_ODDEV_ONLY 3'h0
`define VEOC_SYNC_F_ONLY 3'h1
`define VEOC_SYNC_VSYNC_ONLY 3'h4
`define VEOC_STD_NTSC_M 2'h2
`define VEOC_PEDESTAL_CODE 8'h2a
`define VEOC_GAIN_SETUP 8'h74
`define VEOC_GAIN_NOSETUP 8'h80
`define VEOC_GAIN_PAL 8'h7c
`define VEOC_LINES_625 10'h271
`define VEOC_LINES_525 10'h20d
`define VEOC_LINES_312 10'h138
`define VEOC_LINES_262 10'h106
`define VEOC_RESP_OKAY 2'h0
`define VEOC_RESP_SLVERR 2'h2
`endif

//--- core/veoc_line_timer.v
// frame line counter: lines per field and field parity from scan mode
`timescale 1ns/1ps
`default_nettype none
`include "veoc_map.vh"
module veoc_line_timer (
   input wire clk,
   input wire reset,
   input wire line_start,
   input wire non_interlaced,
   input wire std_625,
   output reg [9:0] line_r,
   output reg field2_r,
   output wire frame_start
);
   wire [9:0] field_len;
   wire last_line;
   // non-interlaced uses two equal short fields
   assign field_len = non_interlaced ? (std_625 ? `VEOC_LINES_312 : `VEOC_LINES_262) //(R10)
                      : (std_625 ? `VEOC_LINES_625 : `VEOC_LINES_525); //(R8)
   assign last_line = (line_r == field_len - 10'h001);
   assign frame_start = line_start & last_line & (non_interlaced ? field2_r : 1'b1);
   // ************
   // line and field counting
   // ************
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         line_r <= 10'h000;
         field2_r <= 1'b0;
      end else if (line_start) begin
         if (last_line) begin
            line_r <= 10'h000;
            field2_r <= non_interlaced ? ~field2_r : 1'b0;
         end else begin
            line_r <= line_r + 10'h001;
            // interlaced: second field starts half way through the frame
            if (!non_interlaced && line_r == {1'b0, field_len[9:1]})
               field2_r <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- core/veoc_config.v
// encoder output configuration: axi4-lite registers and output shaping controls
`timescale 1ns/1ps
`default_nettype none
`include "veoc_map.vh"
module veoc_config (
   input wire clk,
   input wire reset,
   input wire hw_reset_n,
   input wire line_start,
   input wire in_vbi_nominal,
   input wire in_vbi_wide,
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg composite_chroma_en_r,
   output reg composite_burst_en_r,
   output reg [7:0] black_offset_r,
   output reg [7:0] chroma_gain_r,
   output reg [1:0] chroma_filter_sel_r,
   output reg caption_insert_r,
   output reg blank_line_r,
   output reg sync_blank_active_r,
   output reg non_interlaced_r,
   output reg field2_r,
   output reg [9:0] line_r
);
   // ************
   // register state
   // ************
   reg [7:0] options_r;
   reg [7:0] scanosc_r;
   reg [7:0] mode_r;
   reg aw_held_r;
   reg w_held_r;
   reg [4:0] awaddr_r;
   reg [7:0] wbyte_r;
   wire [9:0] line_w;
   wire field2_w;
   wire frame_start;
   wire soft_clr;
   wire do_write;
   wire [1:0] caption_field_mode;
   wire [2:0] sync_mode;
   wire [1:0] std_sel;

   // word decode shared by the response and the register write; mode and unmapped both give 0
   function [1:0] reg_sel;
      input [4:0] a;
      begin
         case ({3'h0, a})
            `VEOC_ADDR_OPTIONS: reg_sel = 2'h1;
            `VEOC_ADDR_SCANOSC: reg_sel = 2'h2;
            `VEOC_ADDR_STATUS: reg_sel = 2'h3;
            default: reg_sel = 2'h0;
         endcase
      end
   endfunction
   function mapped;
      input [4:0] a;
      begin
         mapped = ({3'h0, a} == `VEOC_ADDR_OPTIONS) || ({3'h0, a} == `VEOC_ADDR_SCANOSC) ||
                  ({3'h0, a} == `VEOC_ADDR_STATUS) || ({3'h0, a} == `VEOC_ADDR_MODE);
      end
   endfunction

   assign caption_field_mode = options_r[`VEOC_BIT_CC_HI:`VEOC_BIT_CC_LO];
   assign sync_mode = mode_r[4:2];
   assign std_sel = mode_r[1:0];
   // pin reset acts like the bus reset on the configuration bits only
   assign soft_clr = ~hw_reset_n; //(R1)

   // ************
   // write channel: address and data in either order
   // ************
   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
   assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 5'h00;
         wbyte_r <= 8'h00;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `VEOC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            // only lane 0 carries data; a masked lane holds zero here and its register keeps old byte
            wbyte_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (mapped(awaddr_r) && reg_sel(awaddr_r) != 2'h3) ? `VEOC_RESP_OKAY
                           : `VEOC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   reg wstrb0_r;
   always @(posedge clk or posedge reset) begin
      if (reset)
         wstrb0_r <= 1'b0;
      else if (s_axi_wvalid && s_axi_wready)
         wstrb0_r <= s_axi_wstrb[0];
   end

   // ************
   // configuration registers
   // ************
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         options_r <= `VEOC_RST_OPTIONS; //(R13)
         scanosc_r <= `VEOC_RST_SCANOSC; //(R9)
         mode_r <= `VEOC_RST_MODE;
      end else if (soft_clr) begin
         options_r <= `VEOC_RST_OPTIONS; //(R1)
         scanosc_r <= `VEOC_RST_SCANOSC; //(R9)
         mode_r <= `VEOC_RST_MODE;
      end else if (do_write && wstrb0_r && mapped(awaddr_r)) begin
         // status is read only: its write is refused with an error response
         case (reg_sel(awaddr_r))
            2'h1: options_r <= wbyte_r;
            2'h2: scanosc_r <= wbyte_r & 8'hef; // unused bit reads zero
            2'h0: mode_r <= {3'h0, wbyte_r[4:0]};
            default: mode_r <= mode_r;
         endcase
      end
   end

   // ************
   // read channel: one beat, answer the cycle after arvalid
   // ************
   assign s_axi_arready = ~s_axi_rvalid;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `VEOC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? `VEOC_RESP_OKAY : `VEOC_RESP_SLVERR;
         case ({3'h0, s_axi_araddr})
            `VEOC_ADDR_OPTIONS: s_axi_rdata <= {24'h000000, options_r};
            `VEOC_ADDR_SCANOSC: s_axi_rdata <= {24'h000000, scanosc_r};
            `VEOC_ADDR_STATUS: s_axi_rdata <= {20'h00000, field2_r, non_interlaced_r, line_r};
            `VEOC_ADDR_MODE: s_axi_rdata <= {24'h000000, mode_r};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ************
   // frame timing
   // ************
   veoc_line_timer u_timer (
      .clk(clk),
      .reset(reset),
      .line_start(line_start),
      .non_interlaced(non_interlaced_r),
      .std_625(~std_sel[1]),
      .line_r(line_w),
      .field2_r(field2_w),
      .frame_start(frame_start)
   );

   // ************
   // output shaping controls
   // ************
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         non_interlaced_r <= 1'b0;
         composite_chroma_en_r <= 1'b1;
         composite_burst_en_r <= 1'b1;
         black_offset_r <= 8'h00;
         chroma_gain_r <= `VEOC_GAIN_NOSETUP;
         chroma_filter_sel_r <= 2'h2;
         caption_insert_r <= 1'b0;
         blank_line_r <= 1'b0;
         sync_blank_active_r <= 1'b0;
         field2_r <= 1'b0;
         line_r <= 10'h000;
      end else begin
         // scan change held off to frame start so a frame is cut short only when pin reset loads it at once
         if (frame_start || soft_clr)
            non_interlaced_r <= scanosc_r[`VEOC_BIT_NON_INTERLACED]; //(R11)
         field2_r <= field2_w;
         line_r <= line_w;
         // composite only; chroma and rgb paths never see these
         composite_chroma_en_r <= ~options_r[`VEOC_BIT_COLOUR_KILL]; //(R3)
         composite_burst_en_r <= scanosc_r[`VEOC_BIT_BURST_EN]; //(R12)
         // pedestal only outside the nominal vbi
         if (options_r[`VEOC_BIT_PEDESTAL] && !in_vbi_nominal)
            black_offset_r <= `VEOC_PEDESTAL_CODE; //(R5)
         else
            black_offset_r <= 8'h00; //(R4)
         // for std_sel 2 and 3 gain compensates the pedestal so chroma keeps its amplitude; 0 and 1 take the PAL gain
         if (std_sel != `VEOC_STD_NTSC_M && std_sel != 2'h3)
            chroma_gain_r <= `VEOC_GAIN_PAL; //(R6)
         else
            chroma_gain_r <= options_r[`VEOC_BIT_PEDESTAL] ? `VEOC_GAIN_SETUP : `VEOC_GAIN_NOSETUP; //(R6)
         chroma_filter_sel_r <= options_r[`VEOC_BIT_FLT_HI:`VEOC_BIT_FLT_LO]; //(R13)
         case (caption_field_mode)
            2'h1: caption_insert_r <= ~field2_w; //(R7)
            2'h2: caption_insert_r <= field2_w; //(R7)
            2'h3: caption_insert_r <= 1'b1; //(R7)
            default: caption_insert_r <= 1'b0; //(R7)
         endcase
         // wide vs nominal vbi; cgms and teletext use their own gating
         blank_line_r <= options_r[`VEOC_BIT_BLANK_SEL] ? in_vbi_nominal : in_vbi_wide; //(R14)
         sync_blank_active_r <= options_r[`VEOC_BIT_SYNC_BLANK] &&
            (sync_mode == `VEOC_SYNC_ODDEV_ONLY || sync_mode == `VEOC_SYNC_F_ONLY ||
             sync_mode == `VEOC_SYNC_VSYNC_ONLY); //(R2)
      end
   end
endmodule
`default_nettype wire

//--- test/veoc_config_asserts.sv
// port assertions for the encoder output configuration block
`timescale 1ns/1ps
`default_nettype none
module veoc_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic hw_reset_n,
   input wire logic in_vbi_nominal,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic composite_chroma_en_r,
   input wire logic composite_burst_en_r,
   input wire logic [7:0] black_offset_r,
   input wire logic [7:0] chroma_gain_r,
   input wire logic [1:0] chroma_filter_sel_r
);
   // ************
   // bus handshake and output levels
   // ************
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   a_black_vbi: assert property (in_vbi_nominal |=> black_offset_r == 8'h00)
      else $error("pedestal inside blanking");
   a_black_level: assert property (black_offset_r == 8'h00 || black_offset_r == 8'h2a)
      else $error("black offset off level");
   a_gain_level: assert property (chroma_gain_r inside {8'h74, 8'h80, 8'h7c})
      else $error("chroma gain off level");
   a_hwrst_defaults: assert property (!hw_reset_n ##1 !hw_reset_n |=> composite_chroma_en_r
      && composite_burst_en_r && chroma_filter_sel_r == 2'h2 && black_offset_r == 8'h00)
      else $error("hardware reset defaults missing");
endmodule
bind veoc_config veoc_chk veoc_chk_i (.*);
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the encoder output configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "veoc_map.vh"
module tb;
   localparam logic [1:0] OK = `VEOC_RESP_OKAY;
   localparam logic [1:0] ERR = `VEOC_RESP_SLVERR;
   logic clk = 1'b0, reset = 1'b1, hw_reset_n = 1'b1, line_start = 1'b0;
   logic in_vbi_nominal = 1'b0, in_vbi_wide = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [4:0] s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [1:0] lcnt = 2'h0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp, chroma_filter_sel_r;
   wire logic [31:0] s_axi_rdata;
   wire logic composite_chroma_en_r, composite_burst_en_r, caption_insert_r, blank_line_r;
   wire logic sync_blank_active_r, non_interlaced_r, field2_r;
   wire logic [7:0] black_offset_r, chroma_gain_r;
   wire logic [9:0] line_r;
   int err_total = 0, checked = 0;
   veoc_config veoc_config_i (.*);
   always #10 clk = ~clk;
   // short lines keep a whole frame within a few thousand cycles
   always @(posedge clk) begin
      lcnt <= lcnt + 2'h1;
      line_start <= (lcnt == 2'h3);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a[4:0];
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && dd)) begin
         @(negedge clk);
         ad = ad | (s_axi_awready & s_axi_awvalid);
         dd = dd | (s_axi_wready & s_axi_wvalid);
         @(posedge clk);
         if (ad) s_axi_awvalid <= 1'b0;
         if (dd) s_axi_wvalid <= 1'b0;
      end
      @(negedge clk);
      while (!s_axi_bvalid) @(negedge clk);
      chk(s_axi_bresp, er);
      @(posedge clk);
      s_axi_bready <= 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      s_axi_araddr <= a[4:0];
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge clk);
      while (!s_axi_arready) @(negedge clk);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      @(negedge clk);
      while (!s_axi_rvalid) @(negedge clk);
      chk(s_axi_rdata, {24'h0, e});
      chk(s_axi_rresp, OK);
      @(posedge clk);
      s_axi_rready <= 1'b0;
      // end on a falling edge so later compares never race the clock
      @(negedge clk);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ************
   // test sequence
   // ************
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rd(`VEOC_ADDR_OPTIONS, `VEOC_RST_OPTIONS);
      rd(`VEOC_ADDR_SCANOSC, `VEOC_RST_SCANOSC);
      chk({composite_chroma_en_r, composite_burst_en_r, chroma_filter_sel_r, non_interlaced_r}, 5'h1c);
      $display("test defaults done");
      wr(`VEOC_ADDR_MODE, 8'h02, OK);
      wr(`VEOC_ADDR_OPTIONS, 8'h4c, OK);
      chk({composite_chroma_en_r, black_offset_r, chroma_gain_r}, {1'b0, 8'h2a, 8'h74});
      @(posedge clk);
      in_vbi_nominal <= 1'b1;
      repeat (2) @(negedge clk);
      chk(black_offset_r, 8'h00);
      // active line of the nominal interval but inside the wide one
      @(posedge clk);
      in_vbi_nominal <= 1'b0;
      in_vbi_wide <= 1'b1;
      wr(`VEOC_ADDR_OPTIONS, 8'h40, OK);
      chk({composite_chroma_en_r, black_offset_r, chroma_gain_r, blank_line_r}, {1'b1, 16'h0080, 1'b1});
      wr(`VEOC_ADDR_OPTIONS, 8'hc0, OK);
      chk(blank_line_r, 1'b0);
      for (int f = 0; f < 4; f++) begin
         wr(`VEOC_ADDR_OPTIONS, {1'b0, f[1:0], 5'h00}, OK);
         chk(chroma_filter_sel_r, f[1:0]);
      end
      // first pass early in field 1, second pass once field 2 has begun
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 4; m++) begin
            wr(`VEOC_ADDR_OPTIONS, {6'h00, m[1:0]}, OK);
            chk(caption_insert_r, p[0] ? m[1] : m[0]);
         end
         for (int n = 0; n < 3000 && field2_r !== 1'b1; n++) @(negedge clk);
         chk(field2_r, 1'b1);
      end
      wr(`VEOC_ADDR_OPTIONS, 8'h10, OK);
      for (int s = 0; s < 8; s++) begin
         wr(`VEOC_ADDR_MODE, {3'h0, s[2:0], 2'h0}, OK);
         chk(sync_blank_active_r, s == 0 || s == 1 || s == 4);
      end
      wr(`VEOC_ADDR_MODE, 8'h00, OK);
      chk(chroma_gain_r, `VEOC_GAIN_PAL);
      $display("test options done");
      wr(`VEOC_ADDR_SCANOSC, 8'h00, OK);
      chk(composite_burst_en_r, 1'b0);
      rd(`VEOC_ADDR_SCANOSC, 8'h00);
      // status and unmapped writes must leave the options alone
      wr(`VEOC_ADDR_STATUS, 8'hff, ERR);
      wr(8'h00, 8'hff, ERR);
      rd(`VEOC_ADDR_OPTIONS, 8'h10);
      wr(`VEOC_ADDR_SCANOSC, 8'h80, OK);
      chk(non_interlaced_r, 1'b0);
      for (int n = 0; n < 3000 && non_interlaced_r !== 1'b1; n++) @(negedge clk);
      chk(non_interlaced_r, 1'b1);
      @(negedge clk);
      chk({field2_r, line_r}, 11'h000);
      $display("test scan done");
      @(posedge clk);
      hw_reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      hw_reset_n <= 1'b1;
      rd(`VEOC_ADDR_OPTIONS, `VEOC_RST_OPTIONS);
      rd(`VEOC_ADDR_SCANOSC, `VEOC_RST_SCANOSC);
      rd(`VEOC_ADDR_MODE, `VEOC_RST_MODE);
      chk({composite_burst_en_r, non_interlaced_r}, 2'h2);
      $display("test hardware reset done");
      test_done();
   end
   // watchdog: the sequence needs well under ten thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule
`default_nettype wire
